// [nac_regs.vh]
`ifndef NAC_REGS_VH
`define NAC_REGS_VH
// ----------------------------------------
// Register placement
// ----------------------------------------
`define NAC_CTRL_ADDR      8'h40
`define NAC_CTRL_BANK      1'b1
`define NAC_LOC_ADDR_BANK0 8'h00
`define NAC_BYTE_ADDR_BANK0 8'h01
`define NAC_BANK_ADDR      8'h02
`define NAC_PTR_ADDR       8'h03
`define NAC_IAP_ADDR       8'h04
`define NAC_IRQ_ADDR       8'h05
// ----------------------------------------
// Control bit positions and reset values
// ----------------------------------------
`define NAC_FETCH_BIT      0
`define NAC_FETCH_PERMIT   1
`define NAC_STORE_BIT      2
`define NAC_STORE_PERMIT   3
`define NAC_CTRL_RESET     8'h00
// Interrupt register bits
`define NAC_IRQ_GIE        0
`define NAC_IRQ_NIE        1
`define NAC_IRQ_MIE        2
`define NAC_IRQ_NFLAG      3
`define NAC_IRQ_MFLAG      4
// ----------------------------------------
// Array and timing
// ----------------------------------------
`define NAC_LOC_WIDTH      6
`define NAC_DEPTH          64
`define NAC_WTIMER_DIV     4
`define NAC_WTIMER_TICKS   8'h20
`define NAC_READ_CYCLES    2'h2
`endif

// [nac_wtimer.v]
`timescale 1ns/1ps
// Write-cycle timer: a free-running divider stands in for the asynchronous
// timer, so the write length varies with the phase it starts in.
module nac_wtimer #(
    parameter DIV   = 4,
    parameter TICKS = 32
) (
    input  wire i_sys_clk, // System clock
    input  wire i_rst_n,   // Async reset, active low
    input  wire i_start,   // Start pulse
    output reg  o_busy,    // Cycle running
    output reg  o_done     // End pulse
);
    reg [7:0] div_reg;
    reg [7:0] tick_reg;
    wire      tick = (div_reg == DIV[7:0] - 8'h01);

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg  <= 8'h00;
            tick_reg <= 8'h00;
            o_busy   <= 1'b0;
            o_done   <= 1'b0;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            o_done  <= 1'b0;
            if (i_start && !o_busy) begin
                o_busy   <= 1'b1;
                tick_reg <= 8'h00;
            end else if (o_busy && tick) begin
                if (tick_reg == TICKS[7:0] - 8'h01) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
                tick_reg <= tick_reg + 8'h01;
            end
        end
    end
endmodule

// [nac_array.v]
`timescale 1ns/1ps
// Byte array held in the block; one byte per access.
module nac_array #(
    parameter AW    = 6,
    parameter DEPTH = 64
) (
    input  wire          i_sys_clk, // System clock
    input  wire          i_we,      // Store strobe
    input  wire [AW-1:0] i_addr,    // Location
    input  wire [7:0]    i_wdata,   // Store byte
    output reg  [7:0]    o_rdata    // Fetched byte
);
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule

// [nac_ctrl.v]
`timescale 1ns/1ps
`include "nac_regs.vh"
// Functional notes
// [RQ1] Writes happen only while store_permit (bit 3) is high.
// [RQ2] Setting bit 2 starts a write; hardware clears it when done.
// [RQ3] Store trigger is ignored unless store_permit was already high.
// [RQ4] Reads happen only while fetch_permit (bit 1) is high.
// [RQ5] Setting bit 0 starts a read; hardware clears it when done.
// [RQ6] Fetch trigger is ignored unless fetch_permit was already high.
// [RQ7] Software never sets all four bits, nor both triggers, at once.
// [RQ8] Read fetches byte at nvm_location into nvm_byte before trigger clears.
// [RQ9] nvm_byte keeps read data until the next read or write.
// [RQ10] Software loads location and byte, sets permit, then trigger next.
// [RQ11] Software should mask global interrupts around write start.
// [RQ12] Write length set by a free-running timer; end shown by trigger clearing.
// [RQ13] Reset clears all four control bits, including store_permit.
// [RQ14] Reset selects bank 0, hiding the bank-1 control register.
// [RQ15] Write end sets nvm_irq_flag and the multi-function flag.
// [RQ16] Vector request only with all three enables set and stack not full.
// [RQ17] Service clears only the multi-function flag; software clears nvm_irq_flag.
// [RQ18] Software must not idle or sleep during an access.
// [RQ19] 64-byte array, 6-bit location, single-byte transfers.
// [RQ20] Control register at 40h of bank 1, reached via indirect pointer.
// [RQ21] Location and data are latched at write start.
module nac_ctrl #(
    parameter WT_DIV   = `NAC_WTIMER_DIV,
    parameter WT_TICKS = `NAC_WTIMER_TICKS
) (
    input  wire       i_sys_clk,   // System clock, 100 MHz
    input  wire       i_rst_n,     // Async reset, active low
    input  wire [7:0] i_addr,      // Special register address
    input  wire [7:0] i_wdata,     // Write data
    input  wire       i_wr,        // Write strobe, one cycle
    input  wire       i_rd,        // Read strobe, one cycle
    input  wire       i_stack_full,// Stack full from core
    input  wire       i_irq_ack,   // Vector taken, one cycle
    output reg  [7:0] o_rdata,     // Read data, valid cycle after i_rd
    output reg        o_irq_req,   // Vector request level
    output reg        o_busy       // Access in progress
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [5:0] nvm_location_reg;
    reg [7:0] nvm_byte_reg;
    reg       bank_select_reg;
    reg [7:0] indirect_pointer_reg;
    reg       store_permit_reg;
    reg       store_trig_reg;
    reg       fetch_permit_reg;
    reg       fetch_trig_reg;
    reg [2:0] irq_en_reg;
    reg       nvm_irq_flag_reg;
    reg       mf_flag_reg;
    reg [5:0] wloc_reg;
    reg [7:0] wbyte_reg;
    reg [1:0] rcnt_reg;
    reg       wstart_reg;
    reg       wbusy_seen_reg;

    wire       wt_busy;
    wire       wt_done;
    wire [7:0] arr_rdata;

    wire ctrl_sel = bank_select_reg == `NAC_CTRL_BANK && indirect_pointer_reg == `NAC_CTRL_ADDR; // RQ20
    wire ctrl_wr  = i_wr && i_addr == `NAC_IAP_ADDR && ctrl_sel;
    wire nw_store = i_wdata[`NAC_STORE_BIT];
    wire nw_fetch = i_wdata[`NAC_FETCH_BIT];
    // Trigger is accepted only from a permit already standing before this write
    wire start_w  = ctrl_wr && nw_store && !store_trig_reg && store_permit_reg
                    && i_wdata[`NAC_STORE_PERMIT] && !fetch_trig_reg; // RQ1 RQ3
    wire start_r  = ctrl_wr && nw_fetch && !fetch_trig_reg && fetch_permit_reg
                    && i_wdata[`NAC_FETCH_PERMIT] && !store_trig_reg && !start_w; // RQ4 RQ6
    wire w_end    = wbusy_seen_reg && wt_done;
    wire r_end    = fetch_trig_reg && rcnt_reg == `NAC_READ_CYCLES;
    wire [7:0] ctrl_val = {4'h0, store_permit_reg, store_trig_reg, fetch_permit_reg, fetch_trig_reg};

    nac_wtimer #(.DIV(WT_DIV), .TICKS(WT_TICKS)) u_wtimer (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_start   (wstart_reg),
        .o_busy    (wt_busy),
        .o_done    (wt_done)
    );

    nac_array #(.AW(`NAC_LOC_WIDTH), .DEPTH(`NAC_DEPTH)) u_array ( // RQ19
        .i_sys_clk (i_sys_clk),
        .i_we      (w_end),
        .i_addr    (store_trig_reg ? wloc_reg : nvm_location_reg),
        .i_wdata   (wbyte_reg),
        .o_rdata   (arr_rdata)
    );

    // ----------------------------------------
    // Control and data
    // ----------------------------------------
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nvm_location_reg     <= 6'h00;
            nvm_byte_reg         <= 8'h00;
            bank_select_reg      <= 1'b0; // RQ14
            indirect_pointer_reg <= 8'h00;
            store_permit_reg     <= 1'b0; // RQ13
            store_trig_reg       <= 1'b0;
            fetch_permit_reg     <= 1'b0;
            fetch_trig_reg       <= 1'b0;
            wloc_reg             <= 6'h00;
            wbyte_reg            <= 8'h00;
            rcnt_reg             <= 2'h0;
            wstart_reg           <= 1'b0;
            wbusy_seen_reg       <= 1'b0;
        end else begin
            wstart_reg <= start_w;
            if (wt_busy) begin
                wbusy_seen_reg <= 1'b1;
            end else if (w_end) begin
                wbusy_seen_reg <= 1'b0;
            end
            if (i_wr) begin
                case (i_addr)
                    `NAC_LOC_ADDR_BANK0:  nvm_location_reg <= i_wdata[5:0];
                    `NAC_BYTE_ADDR_BANK0: nvm_byte_reg     <= i_wdata;
                    `NAC_BANK_ADDR:       bank_select_reg  <= i_wdata[0];
                    `NAC_PTR_ADDR:        indirect_pointer_reg <= i_wdata;
                    default: ;
                endcase
            end
            if (ctrl_wr) begin
                store_permit_reg <= i_wdata[`NAC_STORE_PERMIT]; // RQ1
                fetch_permit_reg <= i_wdata[`NAC_FETCH_PERMIT]; // RQ4
            end
            // Writing a zero cannot cancel a running cycle; only hardware ends it
            if (start_w) begin
                store_trig_reg <= 1'b1; // RQ2
                wloc_reg       <= nvm_location_reg; // RQ21
                wbyte_reg      <= nvm_byte_reg;
            end else if (w_end) begin
                store_trig_reg <= 1'b0; // RQ2 RQ12
            end
            if (start_r) begin
                fetch_trig_reg <= 1'b1; // RQ5
                rcnt_reg       <= 2'h0;
            end else if (fetch_trig_reg) begin
                rcnt_reg <= rcnt_reg + 2'h1;
                if (r_end) begin
                    fetch_trig_reg <= 1'b0; // RQ5
                    nvm_byte_reg   <= arr_rdata; // RQ8 RQ9
                end
            end
        end
    end

    // ----------------------------------------
    // Interrupt flags
    // ----------------------------------------
    wire irq_wr = i_wr && i_addr == `NAC_IRQ_ADDR;

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_en_reg       <= 3'h0;
            nvm_irq_flag_reg <= 1'b0;
            mf_flag_reg      <= 1'b0;
            o_irq_req        <= 1'b0;
        end else begin
            if (irq_wr) begin
                irq_en_reg <= i_wdata[2:0];
            end
            // Set wins over a software clear in the same cycle
            if (w_end) begin
                nvm_irq_flag_reg <= 1'b1; // RQ15
                mf_flag_reg      <= 1'b1;
            end else begin
                if (irq_wr && !i_wdata[`NAC_IRQ_NFLAG]) begin
                    nvm_irq_flag_reg <= 1'b0; // RQ17
                end
                if ((irq_wr && !i_wdata[`NAC_IRQ_MFLAG]) || i_irq_ack) begin
                    mf_flag_reg <= 1'b0; // RQ17
                end
            end
            o_irq_req <= irq_en_reg[`NAC_IRQ_GIE] && irq_en_reg[`NAC_IRQ_NIE] && irq_en_reg[`NAC_IRQ_MIE]
                         && mf_flag_reg && nvm_irq_flag_reg && !i_stack_full && !i_irq_ack; // RQ16
        end
    end

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
            o_busy  <= 1'b0;
        end else begin
            o_busy <= store_trig_reg || fetch_trig_reg || start_w || start_r;
            if (i_rd) begin
                case (i_addr)
                    `NAC_LOC_ADDR_BANK0:  o_rdata <= {2'h0, nvm_location_reg};
                    `NAC_BYTE_ADDR_BANK0: o_rdata <= nvm_byte_reg;
                    `NAC_BANK_ADDR:       o_rdata <= {7'h00, bank_select_reg};
                    `NAC_PTR_ADDR:        o_rdata <= indirect_pointer_reg;
                    `NAC_IAP_ADDR:        o_rdata <= ctrl_sel ? ctrl_val : 8'h00;
                    `NAC_IRQ_ADDR:        o_rdata <= {3'h0, mf_flag_reg, nvm_irq_flag_reg, irq_en_reg};
                    default:              o_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

// [nac_ctrl_monitor.sv]
`timescale 1ns/1ps
module nac_ctrl_monitor #(
    parameter WT_DIV   = 4,
    parameter WT_TICKS = 32
) (
    input wire       i_sys_clk,    // System clock
    input wire       i_rst_n,      // Async reset, active low
    input wire [7:0] i_addr,       // Register address
    input wire [7:0] i_wdata,      // Write data
    input wire       i_wr,         // Write strobe
    input wire       i_rd,         // Read strobe
    input wire       i_stack_full, // Stack full
    input wire       i_irq_ack,    // Vector taken
    input wire [7:0] o_rdata,      // Read data
    input wire       o_irq_req,    // Vector request
    input wire       o_busy        // Access running
);
    // ----------------------------------------
    // Shared clocking and sequences
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Generous bound: the timer phase makes a store length vary
    localparam int MAX_CYC = 300;
    sequence s_busy_start;
        !o_busy ##1 o_busy;
    endsequence
    sequence s_busy_end;
        ##[1:MAX_CYC] !o_busy;
    endsequence
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_RST_QUIET: assert property ($rose(i_rst_n) |-> !o_busy && !o_irq_req && o_rdata == 8'h00)
        else $error("outputs not quiet after reset");
    AST_BUSY_ENDS: assert property (s_busy_start |-> s_busy_end)
        else $error("access never finished");
    AST_BUSY_CAUSE: assert property ($rose(o_busy) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
        else $error("access started without a register write");
    AST_BUSY_MIN: assert property (s_busy_start |-> o_busy [*2])
        else $error("access shorter than two cycles");
    AST_RDATA_HOLD: assert property (!$past(i_rd) |-> $stable(o_rdata))
        else $error("read data changed without a read");
    AST_UNMAPPED: assert property (i_rd && i_addr > 8'h05 |=> o_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    AST_LOC_WIDTH: assert property (i_rd && i_addr == 8'h00 |=> o_rdata[7:6] == 2'b00)
        else $error("location upper bits nonzero");
    AST_CTRL_UPPER: assert property (i_rd && i_addr == 8'h04 |=> o_rdata[7:4] == 4'h0)
        else $error("control upper nibble nonzero");
    AST_STACK_FULL: assert property (i_stack_full |=> !o_irq_req)
        else $error("vector request with stack full");
    AST_ACK_CLEARS: assert property (i_irq_ack && !o_busy |-> ##[1:2] !o_irq_req)
        else $error("vector request held after service");
endmodule

// [nac_ctrl_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks = total_checks + 1; if ((got) !== (exp)) begin \
    err_count = err_count + 1; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module nac_ctrl_tb;
    localparam WT_DIV   = 2;
    localparam WT_TICKS = 4;
    reg        i_sys_clk    = 1'b0;
    reg        i_rst_n      = 1'b0;
    reg  [7:0] i_addr       = 8'h00;
    reg  [7:0] i_wdata      = 8'h00;
    reg        i_wr         = 1'b0;
    reg        i_rd         = 1'b0;
    reg        i_stack_full = 1'b0;
    reg        i_irq_ack    = 1'b0;
    wire [7:0] o_rdata;
    wire       o_irq_req;
    wire       o_busy;
    reg  [7:0] rv;
    integer    err_count    = 0;
    integer    total_checks = 0;
    integer    cyc          = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    nac_ctrl #(.WT_DIV(WT_DIV), .WT_TICKS(WT_TICKS)) nac_ctrl_inst (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_stack_full(i_stack_full), .i_irq_ack(i_irq_ack), .o_rdata(o_rdata),
        .o_irq_req(o_irq_req), .o_busy(o_busy));
    // ----------------------------------------
    // Register port tasks
    // ----------------------------------------
    task give_verdict;
        begin
            if (err_count == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge i_sys_clk);
            i_addr  <= a;
            i_wdata <= d;
            i_wr    <= 1'b1;
            @(posedge i_sys_clk);
            i_wr    <= 1'b0;
        end
    endtask
    task rc(input [7:0] a, input [7:0] exp);
        begin
            @(posedge i_sys_clk);
            i_addr <= a;
            i_rd   <= 1'b1;
            @(posedge i_sys_clk);
            i_rd   <= 1'b0;
            #1;
            rv = o_rdata;
            `CHK("register read", exp, rv)
        end
    endtask
    task wait_idle;
        integer n;
        begin
            n = 0;
            #1;
            while (o_busy !== 1'b0 && n < 400) begin
                @(posedge i_sys_clk);
                #1;
                n = n + 1;
            end
            // A cycle that never ends is a failure, not a reason to go on
            if (n >= 400) begin
                err_count = err_count + 1;
                give_verdict;
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge i_sys_clk);
            #1;
        end
    endtask
    // Ceiling well above the hundred or so cycles the sequence needs
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            give_verdict;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rc(8'h00, 8'h00);
        wr(8'h00, 8'hff);
        rc(8'h00, 8'h3f);
        rc(8'h01, 8'h00);
        rc(8'h05, 8'h00);
        wr(8'h04, 8'h0c);
        rc(8'h04, 8'h00);
        `CHK("busy", 1'b0, o_busy)
        wr(8'h02, 8'h01);
        wr(8'h03, 8'h40);
        rc(8'h04, 8'h00);
        // Permit and trigger in one write: permit was not standing before
        wr(8'h04, 8'h0c);
        rc(8'h04, 8'h08);
        `CHK("busy", 1'b0, o_busy)
        wr(8'h04, 8'h03);
        rc(8'h04, 8'h02);
        wr(8'h00, 8'h05);
        wr(8'h01, 8'ha5);
        wr(8'h04, 8'h08);
        wr(8'h04, 8'h0c);
        rc(8'h04, 8'h0c);
        `CHK("busy", 1'b1, o_busy)
        // Location and byte changed mid-store must not reach the array
        wr(8'h00, 8'h06);
        wr(8'h01, 8'hff);
        wait_idle;
        rc(8'h04, 8'h08);
        rc(8'h05, 8'h18);
        wr(8'h00, 8'h05);
        wr(8'h04, 8'h0a);
        wr(8'h04, 8'h0b);
        wait_idle;
        rc(8'h04, 8'h0a);
        rc(8'h01, 8'ha5);
        wr(8'h00, 8'h06);
        rc(8'h01, 8'ha5);
        wr(8'h04, 8'h08);
        wr(8'h04, 8'h09);
        rc(8'h04, 8'h08);
        wr(8'h04, 8'h02);
        wr(8'h04, 8'h06);
        rc(8'h04, 8'h02);
        tick(1);
        `CHK("busy", 1'b0, o_busy)
        wr(8'h05, 8'h1f);
        tick(3);
        `CHK("irq request", 1'b1, o_irq_req)
        @(posedge i_sys_clk);
        i_stack_full <= 1'b1;
        tick(2);
        `CHK("irq request", 1'b0, o_irq_req)
        @(posedge i_sys_clk);
        i_stack_full <= 1'b0;
        tick(2);
        `CHK("irq request", 1'b1, o_irq_req)
        @(posedge i_sys_clk);
        i_irq_ack <= 1'b1;
        @(posedge i_sys_clk);
        i_irq_ack <= 1'b0;
        tick(2);
        `CHK("irq request", 1'b0, o_irq_req)
        rc(8'h05, 8'h0f);
        wr(8'h05, 8'h07);
        rc(8'h05, 8'h07);
        wr(8'h10, 8'hff);
        rc(8'h10, 8'h00);
        give_verdict;
    end
endmodule
bind nac_ctrl nac_ctrl_monitor #(.WT_DIV(WT_DIV), .WT_TICKS(WT_TICKS)) nac_ctrl_monitor_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_stack_full(i_stack_full), .i_irq_ack(i_irq_ack), .o_rdata(o_rdata),
    .o_irq_req(o_irq_req), .o_busy(o_busy));
